// [rtl/evd_dispatch.sv]
/*
 * Exception and interrupt vector dispatch: picks an event, fetches its
 * vector from the system control block and hands stack, program counter
 * and priority level to the sequencer.
 * Assumes external requesters hold their data stable while the request
 * is high and until acknowledged; the memory port answers with one
 * mem_valid pulse per mem_req.
 */
`timescale 1ns/1ps
module evd_dispatch
  import evd_pkg::*;
#(
  parameter int SW_LVLS = 15
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic exc_req,
  input wire evd_pkg::evd_exc_e exc_class,
  input wire logic push_fault,
  input wire logic cur_is,
  input wire logic [4:0] cur_ipl,
  input wire logic wcs_loaded,
  input wire logic [SW_LVLS-1:0] sw_req,
  input wire logic pwr_fail_req,
  input wire logic crd_req,
  input wire logic bp_req,
  input wire logic [3:0] bp_unit,
  input wire logic [1:0] bp_lvl,
  input wire logic pb_req,
  input wire logic [8:0] pb_vec,
  input wire logic [1:0] pb_lvl,
  output logic [3:0] irq_ack,
  output logic [SW_LVLS-1:0] sw_ack,
  output logic irq_block,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [31:0] mem_data,
  output logic disp_valid,
  output evd_pkg::evd_stk_e disp_stack,
  output logic [31:0] disp_pc,
  output logic disp_ipl_load,
  output logic [4:0] disp_ipl,
  output logic [1:0] disp_nparam,
  output logic disp_wcs,
  output logic [13:0] disp_wcs_arg,
  output logic disp_halt
);
  import evd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [9:0] exc_offset(input evd_exc_e c);
    logic [9:0] o;
    o = OFF_RSVI;
    unique case (c)
      EXC_MCHK: o = OFF_MCHK;
      EXC_RSVI: o = OFF_RSVI;
      EXC_CUSTI: o = OFF_CUSTI;
      EXC_RSVOP: o = OFF_RSVOP;
      EXC_RSVAM: o = OFF_RSVAM;
      EXC_ACV: o = OFF_ACV;
      EXC_TNV: o = OFF_TNV;
      EXC_TRACE: o = OFF_TRACE;
      EXC_BPT: o = OFF_BPT;
      EXC_COMPAT: o = OFF_COMPAT;
      EXC_ARITH: o = OFF_ARITH;
      EXC_CHANGE_TO_KERNEL_TRAP: o = OFF_CHANGE_TO_KERNEL_TRAP;
      EXC_CHANGE_TO_EXEC_TRAP: o = OFF_CHANGE_TO_EXEC_TRAP;
      EXC_CHANGE_TO_SUPER_TRAP: o = OFF_CHANGE_TO_SUPER_TRAP;
      EXC_CHANGE_TO_USER_TRAP: o = OFF_CHANGE_TO_USER_TRAP;
      default: o = OFF_RSVI;
    endcase
    return o;
  endfunction

  function automatic logic [1:0] exc_nparam(input evd_exc_e c);
    logic [1:0] n;
    n = 2'h0;
    unique case (c)
      EXC_MCHK: n = NPARAM_IMPL;
      EXC_ACV, EXC_TNV: n = 2'h2;
      EXC_RSVAM, EXC_COMPAT, EXC_ARITH: n = 2'h1;
      EXC_CHANGE_TO_KERNEL_TRAP, EXC_CHANGE_TO_EXEC_TRAP, EXC_CHANGE_TO_SUPER_TRAP, EXC_CHANGE_TO_USER_TRAP: n = 2'h1;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  function automatic logic [3:0] sw_top(input logic [SW_LVLS-1:0] r);
    logic [3:0] lv;
    lv = 4'h0;
    for (int i = 0; i < SW_LVLS; i++) begin
      if (r[i]) begin
        lv = 4'(i + 1);
      end
    end
    return lv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int PIN_W = 21;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {pwr_fail_req, crd_req, bp_req, bp_unit, bp_lvl, pb_req, pb_vec, pb_lvl};
      pin_sync <= pin_meta;
    end
  end

  logic s_pwr, s_crd, s_bp, s_pb;
  logic [3:0] s_bp_unit;
  logic [1:0] s_bp_lvl, s_pb_lvl;
  logic [8:0] s_pb_vec;
  assign {s_pwr, s_crd, s_bp, s_bp_unit, s_bp_lvl, s_pb, s_pb_vec, s_pb_lvl} = pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] cbb;
  evd_state_e state;
  logic [9:0] ev_off;

  always_ff @(posedge ref_clk) begin
    if (reg_wr && reg_addr == REG_CBB) begin
      cbb <= {reg_wdata[31:PAGE_BITS], {PAGE_BITS{1'b0}}};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CBB: reg_rdata <= cbb;
        REG_STAT: reg_rdata <= {state == S_HALT, state != S_IDLE, 20'h0, ev_off};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event selection

  logic [3:0] sw_lvl;
  logic [4:0] bp_ipl, pb_ipl;
  logic take_pwr, take_crd, take_bp, take_pb, take_sw;

  assign sw_lvl = sw_top(sw_req);
  // peripheral request levels map to 14..17
  assign bp_ipl = IPL_DEV_BASE + {3'h0, s_bp_lvl};
  assign pb_ipl = IPL_DEV_BASE + {3'h0, s_pb_lvl};
  assign take_pwr = s_pwr && IPL_PWRF > cur_ipl;
  assign take_crd = !take_pwr && s_crd && IPL_CRD > cur_ipl;
  assign take_bp = !take_pwr && !take_crd && s_bp && bp_ipl > cur_ipl &&
                   !(s_pb && pb_ipl > bp_ipl);
  assign take_pb = !take_pwr && !take_crd && !take_bp && s_pb && pb_ipl > cur_ipl;
  assign take_sw = !take_pwr && !take_crd && !take_bp && !take_pb &&
                   sw_lvl != 4'h0 && {1'b0, sw_lvl} > cur_ipl;

  logic any_irq;
  logic start;
  assign any_irq = take_pwr || take_crd || take_bp || take_pb || take_sw;
  assign start = state == S_IDLE && (push_fault || exc_req || any_irq);

  logic ev_exc, ev_ksnv, ev_chm;
  logic [1:0] ev_chm_mode;
  logic [4:0] ev_ipl;
  logic [1:0] ev_nparam;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ev_off <= 10'h0;
      ev_exc <= 1'b0;
      ev_ksnv <= 1'b0;
      ev_chm <= 1'b0;
      ev_chm_mode <= 2'h0;
      ev_ipl <= 5'h0;
      ev_nparam <= 2'h0;
    end else if (start) begin
      ev_ksnv <= push_fault;
      ev_exc <= push_fault || exc_req;
      ev_chm <= !push_fault && exc_req && exc_class >= EXC_CHANGE_TO_KERNEL_TRAP;
      ev_chm_mode <= 2'(exc_class - EXC_CHANGE_TO_KERNEL_TRAP);
      ev_ipl <= cur_ipl;
      ev_nparam <= 2'h0;
      if (push_fault) begin
        ev_off <= OFF_KSNV;
      end else if (exc_req) begin
        ev_off <= exc_offset(exc_class);
        ev_nparam <= exc_nparam(exc_class);
      end else if (take_pwr) begin
        ev_off <= OFF_PWRF;
        ev_ipl <= IPL_PWRF;
      end else if (take_crd) begin
        ev_off <= OFF_CRD;
        ev_ipl <= IPL_CRD;
        ev_nparam <= NPARAM_IMPL;
      end else if (take_bp) begin
        ev_off <= OFF_BP_BASE + {2'h0, s_bp_lvl, s_bp_unit, 2'h0};
        ev_ipl <= bp_ipl;
      end else if (take_pb) begin
        ev_off <= OFF_PB_BASE + {1'b0, s_pb_vec[8:2], 2'h0};
        ev_ipl <= pb_ipl;
      end else begin
        ev_off <= OFF_SW_BASE + {4'h0, sw_lvl, 2'h0};
        ev_ipl <= {1'b0, sw_lvl};
      end
    end
  end

  // acknowledge the chosen interrupt source
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= 4'h0;
      sw_ack <= '0;
    end else begin
      irq_ack <= '0;
      sw_ack <= '0;
      if (start && !push_fault && !exc_req) begin
        irq_ack <= {take_pb, take_bp, take_crd, take_pwr};
        if (take_sw) begin
          sw_ack <= SW_LVLS'(1) << (sw_lvl - 4'h1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch sequencer

  evd_stk_e dec_stack;
  logic [31:0] dec_pc;
  logic dec_ipl_load, dec_wcs, dec_halt;
  logic [4:0] dec_ipl;
  logic [13:0] dec_wcs_arg;
  logic fetched;

  assign fetched = state == S_FETCH && mem_valid;

  evd_vec_decode u_decode (
    .vec(mem_data),
    .cur_is(cur_is),
    .is_exc(ev_exc),
    .ksnv(ev_ksnv),
    .chm(ev_chm),
    .chm_mode(ev_chm_mode),
    .ev_ipl(ev_ipl),
    .wcs_loaded(wcs_loaded),
    .stack(dec_stack),
    .pc(dec_pc),
    .ipl_load(dec_ipl_load),
    .interrupt_priority_level(dec_ipl),
    .wcs(dec_wcs),
    .wcs_arg(dec_wcs_arg),
    .halt(dec_halt)
  );

  evd_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_valid) begin
          next_state = dec_halt ? S_HALT : S_IDLE;
        end
      end
      S_HALT: next_state = S_HALT;
      default: next_state = S_HALT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0;
    end else if (start) begin
      mem_req <= 1'b1;
      // offset lands one cycle later
      mem_addr <= cbb;
    end else if (state == S_FETCH) begin
      mem_req <= !mem_valid;
      mem_addr <= cbb + {22'h0, ev_off};
    end else begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_block <= 1'b0;
    end else begin
      irq_block <= next_state != S_IDLE;
    end
  end

  // present results one cycle after the vector
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      disp_valid <= 1'b0;
      disp_stack <= STK_KERNEL;
      disp_pc <= 32'h0;
      disp_ipl_load <= 1'b0;
      disp_ipl <= 5'h0;
      disp_nparam <= 2'h0;
      disp_wcs <= 1'b0;
      disp_wcs_arg <= 14'h0;
    end else begin
      disp_valid <= fetched && !dec_halt;
      if (fetched) begin
        disp_stack <= dec_stack;
        disp_pc <= dec_pc;
        disp_ipl_load <= dec_ipl_load;
        disp_ipl <= dec_ipl;
        disp_nparam <= ev_nparam;
        disp_wcs <= dec_wcs;
        disp_wcs_arg <= dec_wcs_arg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      disp_halt <= 1'b0;
    end else if (fetched && dec_halt) begin
      disp_halt <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_fetch_addr: assert property (state == S_FETCH && mem_req && $past(state) == S_FETCH
      |-> mem_addr == cbb + {22'h0, ev_off})
    else $error("vector fetch address is not base plus offset");

  a_busy_blocks: assert property (mem_req |-> irq_block)
    else $error("interrupts not blocked during vector fetch");

  a_one_fetch: assert property (disp_valid |-> $past(fetched))
    else $error("dispatch without a vector fetch");

  a_ksnv_stack: assert property (fetched && ev_ksnv && mem_data[1] == 1'b0
      |=> disp_valid && disp_stack == STK_INTR && disp_ipl_load && disp_ipl == 5'h1f)
    else $error("kernel-stack-invalid not on interrupt stack at level 1f");

  a_code0_stack: assert property (fetched && !ev_chm && !ev_ksnv && mem_data[1:0] == 2'h0
      |=> disp_stack == ($past(cur_is) ? STK_INTR : STK_KERNEL))
    else $error("code 0 picked the wrong stack");

  a_code1_ipl: assert property (fetched && ev_exc && !ev_chm && mem_data[1:0] == 2'h1
      |=> disp_stack == STK_INTR && disp_ipl == 5'h1f && disp_ipl_load)
    else $error("code 1 exception did not raise level to 1f");

  a_pc_load: assert property (fetched && !mem_data[1]
      |=> disp_pc == {$past(mem_data[31:2]), 2'b00})
    else $error("program counter not taken from vector");

  a_wcs_arg: assert property (fetched && !ev_chm && mem_data[1:0] == 2'h2 && wcs_loaded
      |=> disp_wcs && disp_wcs_arg == $past(mem_data[15:2]))
    else $error("control store escape argument wrong");

  a_rsvd_halt: assert property (fetched && !ev_chm && mem_data[1:0] == 2'h3
      |=> disp_halt && !disp_valid ##1 state == S_HALT && irq_block)
    else $error("reserved code did not halt");

  a_chm_stack: assert property (fetched && ev_chm
      |=> disp_valid && disp_stack == evd_stk_e'({1'b0, $past(ev_chm_mode)}))
    else $error("change-mode trap on wrong stack");

  a_push_ksnv: assert property (state == S_IDLE && push_fault
      |=> ev_off == 10'h008 && state == S_FETCH)
    else $error("stack fault did not start kernel-stack-invalid");

  a_pb_range: assert property (state == S_FETCH && !ev_exc && ev_off >= 10'h200
      |-> ev_off <= 10'h3fc && ev_off[1:0] == 2'h0)
    else $error("peripheral vector offset out of range");

  a_base_align: assert property (reg_wr && reg_addr == REG_CBB
      |=> cbb[8:0] == 9'h0)
    else $error("control block base not page aligned");

endmodule // evd_dispatch

// [rtl/evd_pkg.sv]
/*
 * Shared constants and types for the exception vector dispatch block:
 * control block offsets, priority levels, vector codes, register map,
 * state and event enumerations.
 * Assumes a 32-bit physical address space and 512-byte pages.
 */
package evd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // control block layout
  localparam int PAGE_BITS = 9;
  localparam logic [9:0] OFF_MCHK = 10'h004;
  localparam logic [9:0] OFF_KSNV = 10'h008;
  localparam logic [9:0] OFF_PWRF = 10'h00c;
  localparam logic [9:0] OFF_RSVI = 10'h010;
  localparam logic [9:0] OFF_CUSTI = 10'h014;
  localparam logic [9:0] OFF_RSVOP = 10'h018;
  localparam logic [9:0] OFF_RSVAM = 10'h01c;
  localparam logic [9:0] OFF_ACV = 10'h020;
  localparam logic [9:0] OFF_TNV = 10'h024;
  localparam logic [9:0] OFF_TRACE = 10'h028;
  localparam logic [9:0] OFF_BPT = 10'h02c;
  localparam logic [9:0] OFF_COMPAT = 10'h030;
  localparam logic [9:0] OFF_ARITH = 10'h034;
  localparam logic [9:0] OFF_CHANGE_TO_KERNEL_TRAP = 10'h040;
  localparam logic [9:0] OFF_CHANGE_TO_EXEC_TRAP = 10'h044;
  localparam logic [9:0] OFF_CHANGE_TO_SUPER_TRAP = 10'h048;
  localparam logic [9:0] OFF_CHANGE_TO_USER_TRAP = 10'h04c;
  localparam logic [9:0] OFF_CRD = 10'h054;
  localparam logic [9:0] OFF_SW_BASE = 10'h080;
  localparam logic [9:0] OFF_BP_BASE = 10'h100;
  localparam logic [9:0] OFF_PB_BASE = 10'h200;
  localparam logic [9:0] OFF_PB_LAST = 10'h3fc;

  ////////////////////////////////////////////////////////////////////////////
  // priority levels and vector codes
  localparam logic [4:0] IPL_HIGH = 5'h1f;
  localparam logic [4:0] IPL_PWRF = 5'h1e;
  localparam logic [4:0] IPL_CRD = 5'h1a;
  localparam logic [4:0] IPL_DEV_BASE = 5'h14;
  localparam logic [1:0] VC_KSTK = 2'h0;
  localparam logic [1:0] VC_ISTK = 2'h1;
  localparam logic [1:0] VC_WCS = 2'h2;
  localparam logic [1:0] VC_RSVD = 2'h3;
  localparam logic [1:0] NPARAM_IMPL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [3:0] REG_CBB = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int STAT_HALT_BIT = 31;
  localparam int STAT_BUSY_BIT = 30;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    EXC_MCHK, EXC_RSVI, EXC_CUSTI, EXC_RSVOP, EXC_RSVAM, EXC_ACV, EXC_TNV,
    EXC_TRACE, EXC_BPT, EXC_COMPAT, EXC_ARITH, EXC_CHANGE_TO_KERNEL_TRAP, EXC_CHANGE_TO_EXEC_TRAP,
    EXC_CHANGE_TO_SUPER_TRAP, EXC_CHANGE_TO_USER_TRAP
  } evd_exc_e;

  typedef enum logic [2:0] {
    STK_KERNEL = 3'h0,
    STK_EXEC = 3'h1,
    STK_SUPER = 3'h2,
    STK_USER = 3'h3,
    STK_INTR = 3'h4
  } evd_stk_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_FETCH = 3'b010,
    S_HALT = 3'b100
  } evd_state_e;

endpackage

// [rtl/evd_vec_decode.sv]
/*
 * Combinational interpretation of a fetched vector longword.
 * Assumes the caller registers the results and supplies the latched
 * event attributes alongside the vector.
 */
`timescale 1ns/1ps
module evd_vec_decode
  import evd_pkg::*;
(
  input wire logic [31:0] vec,
  input wire logic cur_is,
  input wire logic is_exc,
  input wire logic ksnv,
  input wire logic chm,
  input wire logic [1:0] chm_mode,
  input wire logic [4:0] ev_ipl,
  input wire logic wcs_loaded,
  output evd_pkg::evd_stk_e stack,
  output logic [31:0] pc,
  output logic ipl_load,
  output logic [4:0] interrupt_priority_level,
  output logic wcs,
  output logic [13:0] wcs_arg,
  output logic halt
);

  always_comb begin
    pc = {vec[31:2], 2'b00};
    stack = STK_KERNEL;
    ipl_load = 1'b0;
    interrupt_priority_level = ev_ipl;
    wcs = 1'b0;
    wcs_arg = vec[15:2];
    halt = 1'b0;
    if (chm) begin
      stack = evd_stk_e'({1'b0, chm_mode});
    end else if (vec[1:0] == VC_RSVD) begin
      halt = 1'b1;
    end else if (vec[1:0] == VC_WCS) begin
      wcs = wcs_loaded;
      halt = !wcs_loaded;
    end else if (ksnv) begin
      stack = STK_INTR;
      ipl_load = 1'b1;
      interrupt_priority_level = IPL_HIGH;
    end else if (vec[1:0] == VC_ISTK) begin
      stack = STK_INTR;
      ipl_load = 1'b1;
      interrupt_priority_level = is_exc ? IPL_HIGH : ev_ipl;
    end else begin
      stack = cur_is ? STK_INTR : STK_KERNEL;
      ipl_load = !is_exc;
    end
  end

endmodule // evd_vec_decode

// [tb/evd_mem_model.sv]
/*
 * Memory model holding control block vectors; answers each fetch once.
 * Assumes the fetch address settles one cycle after the request rises.
 */
`timescale 1ns/1ps
module evd_mem_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_valid,
  output logic [31:0] mem_data
);
  logic [31:0] vt [0:255];
  logic [31:0] last_addr;
  logic [7:0] cnt;
  int dly = 2;

  ////////////////////////////////////////////////////////////////////////////
  // one longword per fetch
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h0;
      mem_valid <= 1'b0;
      mem_data <= 32'h0;
    end else begin
      mem_valid <= 1'b0;
      // released bus keeps changing
      mem_data <= ~mem_data;
      if (mem_req && cnt != 8'hff) begin
        cnt <= cnt + 8'h1;
        if (cnt == dly[7:0]) begin
          mem_valid <= 1'b1;
          mem_data <= vt[mem_addr[9:2]];
          last_addr <= mem_addr;
          cnt <= 8'hff;
        end
      end else if (!mem_req) begin
        cnt <= 8'h0;
      end
    end
  end
endmodule // evd_mem_model

// [tb/tb.sv]
/*
 * Self-checking bench for the vector dispatch block.
 * Assumes the memory model answers fetches; requests held until taken.
 */
`timescale 1ns/1ps
module tb;
  import evd_pkg::*;
  logic ref_clk, nrst, reg_wr, reg_rd, exc_req, push_fault, cur_is, wcs_loaded;
  logic pwr_fail_req, crd_req, bp_req, pb_req, mem_req, mem_valid, disp_valid;
  logic disp_ipl_load, disp_wcs, disp_halt, irq_block;
  logic [3:0] reg_addr, bp_unit, irq_ack;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_data, disp_pc;
  logic [4:0] cur_ipl, disp_ipl;
  logic [14:0] sw_req, sw_ack;
  logic [1:0] bp_lvl, pb_lvl, disp_nparam;
  logic [8:0] pb_vec;
  logic [13:0] disp_wcs_arg;
  evd_exc_e exc_class;
  evd_stk_e disp_stack;
  int fail_count = 0;
  int checked = 0;
  localparam logic [31:0] BASE = 32'h00012200;

  evd_dispatch dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .exc_req, .exc_class, .push_fault, .cur_is, .cur_ipl, .wcs_loaded,
    .sw_req, .pwr_fail_req, .crd_req, .bp_req, .bp_unit, .bp_lvl, .pb_req, .pb_vec,
    .pb_lvl, .irq_ack, .sw_ack, .irq_block, .mem_req, .mem_addr, .mem_valid,
    .mem_data, .disp_valid, .disp_stack, .disp_pc, .disp_ipl_load, .disp_ipl,
    .disp_nparam, .disp_wcs, .disp_wcs_arg, .disp_halt);
  evd_mem_model mem (.ref_clk, .nrst, .mem_req, .mem_addr, .mem_valid, .mem_data);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(reg_rdata, e);
  endtask

  // stk 7 means stack and level not judged
  task automatic ev(input int src, input evd_exc_e cls, input logic [9:0] off,
                    input logic [31:0] vec, input logic [2:0] stk, input logic [4:0] interrupt_priority_level);
    mem.vt[8'((BASE + {22'h0, off}) >> 2)] = vec;
    exc_class <= cls;
    case (src)
      0: exc_req <= 1'b1;
      1: push_fault <= 1'b1;
      2: pwr_fail_req <= 1'b1;
      3: crd_req <= 1'b1;
      4: sw_req <= 15'h2;
      5: bp_req <= 1'b1;
      default: pb_req <= 1'b1;
    endcase
    repeat (20) begin
      @(posedge ref_clk);
      if (mem_req) break;
    end
    {exc_req, push_fault, pwr_fail_req, crd_req, bp_req, pb_req} <= 6'h0;
    sw_req <= 15'h0;
    chk(irq_block, 1'b1);
    chk(irq_ack, (src == 2) ? 32'h1 : (src == 3) ? 32'h2 :
                 (src == 5) ? 32'h4 : (src == 6) ? 32'h8 : 32'h0);
    chk(sw_ack, (src == 4) ? 32'h2 : 32'h0);
    repeat (30) begin
      @(posedge ref_clk);
      if (disp_valid || disp_halt) break;
    end
    chk(disp_valid, vec[1:0] != 2'h3);
    chk(mem.last_addr, BASE + {22'h0, off});
    if (stk != 3'h7) begin
      chk(disp_stack, stk);
      chk(disp_ipl_load, interrupt_priority_level != 5'h0);
      if (interrupt_priority_level != 5'h0) chk(disp_ipl, interrupt_priority_level);
      if (vec[1:0] < 2'h2) chk(disp_pc, {vec[31:2], 2'h0});
    end
    $display("test %h done", off);
  endtask

  task automatic t_halt;
    ev(0, EXC_RSVAM, OFF_RSVAM, 32'h80000003, 3'h7, 5'h0);
    chk(disp_halt, 1'b1);
    rd(4'h4, {2'h3, 20'h0, OFF_RSVAM});
    pwr_fail_req <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(mem_req, 1'b0);
    chk(irq_block, 1'b1);
    pwr_fail_req <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(disp_halt, 1'b0);
    $display("test halt done");
  endtask

  // level not above current is held off
  task automatic t_mask;
    cur_ipl <= IPL_CRD;
    crd_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(mem_req, 1'b0);
    chk(irq_ack, 4'h0);
    crd_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cur_ipl <= 5'h0;
    $display("test mask done");
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  initial begin
    {nrst, reg_wr, reg_rd, exc_req, push_fault, cur_is, wcs_loaded} = 7'h0;
    {pwr_fail_req, crd_req, bp_req, pb_req} = 4'h0;
    {reg_addr, bp_unit, bp_lvl, pb_lvl, pb_vec, sw_req} = 36'h0;
    {reg_wdata, cur_ipl} = 37'h0;
    exc_class = EXC_ACV;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    wr(4'h0, 32'h000123ff);
    rd(4'h0, BASE);
    rd(4'h8, 32'h0);
    ev(0, EXC_ACV, OFF_ACV, 32'h80001000, STK_KERNEL, 5'h0);
    chk(disp_nparam, 2'h2);
    rd(4'h4, {22'h0, OFF_ACV});
    cur_is <= 1'b1;
    ev(0, EXC_TNV, OFF_TNV, 32'h80001100, STK_INTR, 5'h0);
    cur_is <= 1'b0;
    ev(0, EXC_BPT, OFF_BPT, 32'h80001201, STK_INTR, IPL_HIGH);
    chk(disp_nparam, 2'h0);
    ev(1, EXC_ACV, OFF_KSNV, 32'h80001301, STK_INTR, IPL_HIGH);
    chk(disp_nparam, 2'h0);
    ev(0, EXC_CHANGE_TO_USER_TRAP, OFF_CHANGE_TO_USER_TRAP, 32'h80001401, STK_USER, 5'h0);
    ev(2, EXC_ACV, OFF_PWRF, 32'h80001501, STK_INTR, IPL_PWRF);
    mem.dly = 6;
    ev(3, EXC_ACV, OFF_CRD, 32'h80001601, STK_INTR, IPL_CRD);
    chk(disp_nparam, NPARAM_IMPL);
    ev(4, EXC_ACV, 10'h088, 32'h80001700, STK_KERNEL, 5'h02);
    mem.dly = 2;
    bp_unit <= 4'hf;
    bp_lvl <= 2'h3;
    ev(5, EXC_ACV, 10'h1fc, 32'h80001801, STK_INTR, 5'h17);
    pb_vec <= 9'h1fc;
    pb_lvl <= 2'h3;
    ev(6, EXC_ACV, 10'h3fc, 32'h80001901, STK_INTR, 5'h17);
    wcs_loaded <= 1'b1;
    ev(0, EXC_RSVOP, OFF_RSVOP, 32'h0000abc6, 3'h7, 5'h0);
    chk(disp_wcs, 1'b1);
    chk(disp_wcs_arg, 14'h2af1);
    t_mask();
    t_halt();
    conclude();
  end
endmodule // tb
